//--- hdl/fcs_pkg.sv
package fcs_pkg;

    // mode pin codes, high pin first
    localparam logic [2:0] MODE_MSERIAL = 3'h0;
    localparam logic [2:0] MODE_SSERIAL = 3'h7;
    localparam logic [2:0] MODE_MBYTE = 3'h3;
    localparam logic [2:0] MODE_SBYTE = 3'h6;
    localparam logic [2:0] MODE_BSCAN = 3'h5;

    typedef enum logic [2:0]
    {
        ST_CLEAR = 3'h0,
        ST_WAIT_INIT = 3'h1,
        ST_LOAD = 3'h2,
        ST_GSR = 3'h3,
        ST_STARTUP = 3'h4,
        ST_RUN = 3'h5
    } fcs_state_type;

    // register byte offsets
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_COUNT = 4'h8;
    localparam logic [3:0] REG_CHECK = 4'hc;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // control fields
    localparam int CTRL_W = 8;
    localparam int CTRL_PROG_BIT = 0;
    localparam int CTRL_WAIT_BIT = 1;
    localparam int CTRL_DONE_LSB = 2;
    localparam int CTRL_GTS_LSB = 4;
    localparam int CTRL_GWE_LSB = 6;
    localparam logic [7:0] CTRL_RESET = 8'h90;

    // status fields
    localparam int STAT_W = 12;
    localparam int STAT_MODE_LSB = 3;
    localparam int STAT_INIT_BIT = 6;
    localparam int STAT_DONE_BIT = 7;
    localparam int STAT_GTS_BIT = 8;
    localparam int STAT_GWE_BIT = 9;
    localparam int STAT_PULL_BIT = 10;
    localparam int STAT_FULL_BIT = 11;

    // timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int CFG_CLOCK_HALF_NS = 100;
    localparam int CFG_CLOCK_HALF_CYC =
        (CFG_CLOCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [1:0] STARTUP_LAST = 2'h3;

    function automatic logic fcs_is_serial(input logic [2:0] m);
        return (m == MODE_MSERIAL) || (m == MODE_SSERIAL);
    endfunction : fcs_is_serial

    function automatic logic fcs_is_master(input logic [2:0] m);
        return (m == MODE_MSERIAL) || (m == MODE_MBYTE);
    endfunction : fcs_is_master

endpackage : fcs_pkg

//--- hdl/fcs_config_sequencer.sv
// Overview of operation
// - mode pins high-to-low: 000/111 serial, 011/110 byte-wide, 101 scan.
// - master modes drive the config clock; serial 1 bit, byte-wide 8 bits.
// - serial data out for downstream devices only in serial modes.
// - pull-up control pin alone switches pull-ups, whatever the mode.
// - scan port loads in every mode; scan code only disables others.
// - phases in order: clear memory, load data, start-up.
// - configuration starts by itself after power-up unless delayed.
// - init held low in clear; load waits while init is held low.
// - program request restarts everything from memory clearing.
// - init released after clear; done pin high when finished.
// - global set/reset pulsed after last load, before start-up.
// - default: 3-state released one cycle after done rises.
// - default: write enable released one cycle after 3-state release.
// - options move done, 3-state and write-enable release steps.
// - optionally 3-state and write-enable releases wait until the shared done line is high.
`timescale 1ns/1ns
`default_nettype none
module fcs_config_sequencer
    import fcs_pkg::*;
#(
    parameter int CLEAR_CYCLES = 16,
    parameter int LOAD_BITS = 64
)
(
    // bus clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write
    input wire logic awvalid,
    output logic awready,
    input wire logic [3:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // axi4-lite read
    input wire logic arvalid,
    output logic arready,
    input wire logic [3:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // mode pins
    input wire logic mode_sel_hi,
    input wire logic mode_sel_mid,
    input wire logic mode_sel_lo,
    input wire logic pullup_control,
    input wire logic program_request_n,
    output logic pullup_enable,
    // configuration clock
    input wire logic cfg_clock,
    output logic cfg_clock_out,
    output logic cfg_clock_oe,
    // load data
    input wire logic [7:0] cfg_data,
    input wire logic cfg_strobe,
    input wire logic tap_bit,
    input wire logic tap_strobe,
    output logic dout,
    output logic dout_oe,
    // open-drain init and done
    input wire logic init_in,
    output logic init_out,
    output logic init_oe,
    input wire logic done_in,
    output logic done_out,
    output logic done_oe,
    // global controls
    output logic global_set_reset,
    output logic global_output_tristate,
    output logic global_write_enable
);

    localparam int CNT_W = $clog2(LOAD_BITS + 8) + 1;
    localparam int CLR_W = $clog2(CLEAR_CYCLES) + 1;

    if (CLEAR_CYCLES < 1 || LOAD_BITS < 8 || LOAD_BITS % 8 != 0)
    begin : g_bad_param
        $error("fcs_config_sequencer: bad parameters");
    end

    // bus domain state
    logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
    logic aw_hold_ff, w_hold_ff;
    logic [3:0] aw_addr_ff;
    logic [7:0] w_byte_ff;
    logic w_lane_ff;
    logic [1:0] bresp_ff, rresp_ff;
    logic [31:0] rdata_ff;
    logic [CTRL_W-1:0] ctrl_ff;
    logic [2:0] mode_a1_ff, mode_a_ff;
    logic pull_a1_ff, pull_a_ff, pullup_enable_ff;
    logic [7:0] div_ff;
    logic cfg_clock_ff, cfg_clock_oe_ff;
    logic req_ff, ack_a1_ff, ack_a_ff;
    logic [STAT_W-1:0] stat_ff;
    logic [CNT_W-1:0] cnt_a_ff;
    logic [7:0] check_a_ff;

    // link domain state
    logic lrst1_ff, lrst_n_ff;
    logic [5:0] pin1_ff, pin_ff;
    logic [CTRL_W-1:0] ctrl1_ff, ctrl2_ff, ctrl3_ff, ctrl_s_ff;
    logic req1_ff, req2_ff, req3_ff, ack_ff;
    fcs_state_type state_ff, nxt_state;
    logic [CLR_W-1:0] clr_ff, nxt_clr;
    logic [CNT_W-1:0] cnt_ff, nxt_cnt;
    logic [2:0] mode_ff, nxt_mode;
    logic [1:0] step_ff, nxt_step;
    logic [7:0] check_ff, nxt_check;
    logic full_ff;
    logic [STAT_W-1:0] snap_ff;
    logic [CNT_W-1:0] snap_cnt_ff;
    logic [7:0] snap_check_ff;
    logic init_oe_ff, done_oe_ff, gsr_ff, gts_ff, gwe_ff;
    logic nxt_done_oe, nxt_gts, nxt_gwe;
    logic dout_ff, dout_oe_ff;

    // bus decode
    wire aw_take = awvalid && awready_ff;
    wire w_take = wvalid && wready_ff;
    wire do_write = aw_hold_ff && w_hold_ff && !bvalid_ff;
    wire wr_ctrl = do_write && (aw_addr_ff == REG_CTRL);
    wire ar_take = arvalid && arready_ff;
    wire ar_ctrl = araddr == REG_CTRL;
    wire ar_stat = araddr == REG_STATUS;
    wire ar_cnt = araddr == REG_COUNT;
    wire ar_chk = araddr == REG_CHECK;
    wire ar_hit = ar_ctrl || ar_stat || ar_cnt || ar_chk;
    wire [31:0] rd_word =
        ar_ctrl ? {{(32-CTRL_W){1'b0}}, ctrl_ff} :
        ar_stat ? {{(32-STAT_W){1'b0}}, stat_ff} :
        ar_cnt ? {{(32-CNT_W){1'b0}}, cnt_a_ff} :
        ar_chk ? {24'h0, check_a_ff} : 32'h0;
    wire snap_take = ack_a_ff == req_ff;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awready_ff <= 1'b1;
            wready_ff <= 1'b1;
            aw_hold_ff <= 1'b0;
            w_hold_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
            ctrl_ff <= CTRL_RESET;
        end
        else
        begin
            if (aw_take)
            begin
                awready_ff <= 1'b0;
                aw_hold_ff <= 1'b1;
                aw_addr_ff <= awaddr;
            end
            if (w_take)
            begin
                wready_ff <= 1'b0;
                w_hold_ff <= 1'b1;
                w_byte_ff <= wdata[7:0];
                w_lane_ff <= wstrb[0];
            end
            if (do_write)
            begin
                bvalid_ff <= 1'b1;
                bresp_ff <= (aw_addr_ff[1:0] == 2'h0 &&
                    aw_addr_ff[3:2] <= REG_CHECK[3:2]) ? RESP_OKAY : RESP_SLVERR;
            end
            if (wr_ctrl && w_lane_ff)
                ctrl_ff <= w_byte_ff;
            if (bvalid_ff && bready)
            begin
                bvalid_ff <= 1'b0;
                aw_hold_ff <= 1'b0;
                w_hold_ff <= 1'b0;
                awready_ff <= 1'b1;
                wready_ff <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready_ff <= 1'b1;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0;
            rresp_ff <= RESP_OKAY;
        end
        else if (ar_take)
        begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b1;
            rdata_ff <= rd_word;
            rresp_ff <= ar_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (rvalid_ff && rready)
        begin
            rvalid_ff <= 1'b0;
            arready_ff <= 1'b1;
        end
    end

    // pins seen from the bus clock, master clock divider
    always_ff @(posedge aclk)
    begin
        mode_a1_ff <= {mode_sel_hi, mode_sel_mid, mode_sel_lo};
        mode_a_ff <= mode_a1_ff;
        pull_a1_ff <= pullup_control;
        pull_a_ff <= pull_a1_ff;
        ack_a1_ff <= ack_ff;
        ack_a_ff <= ack_a1_ff;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            div_ff <= 8'h0;
            cfg_clock_ff <= 1'b0;
            cfg_clock_oe_ff <= 1'b0;
            pullup_enable_ff <= 1'b0;
        end
        else
        begin
            pullup_enable_ff <= pull_a_ff;
            cfg_clock_oe_ff <= fcs_is_master(mode_a_ff);
            div_ff <= (div_ff == 8'(CFG_CLOCK_HALF_CYC - 1)) ? 8'h0 : div_ff + 8'h1;
            if (div_ff == 8'(CFG_CLOCK_HALF_CYC - 1))
                cfg_clock_ff <= !cfg_clock_ff;
        end
    end

    // status snapshot handshake
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            req_ff <= 1'b0;
            stat_ff <= '0;
            cnt_a_ff <= '0;
            check_a_ff <= 8'h0;
        end
        else if (snap_take)
        begin
            req_ff <= !req_ff;
            stat_ff <= snap_ff;
            cnt_a_ff <= snap_cnt_ff;
            check_a_ff <= snap_check_ff;
        end
    end

    // link domain: reset, pin and control synchronisers
    always_ff @(posedge cfg_clock)
    begin
        lrst1_ff <= aresetn;
        lrst_n_ff <= lrst1_ff;
        pin1_ff <= {mode_sel_hi, mode_sel_mid, mode_sel_lo,
            program_request_n, init_in, done_in};
        pin_ff <= pin1_ff;
        ctrl1_ff <= ctrl_ff;
        ctrl2_ff <= ctrl1_ff;
        ctrl3_ff <= ctrl2_ff;
        // take the control word only once two samples agree
        if (ctrl2_ff == ctrl3_ff)
            ctrl_s_ff <= ctrl3_ff;
        req1_ff <= req_ff;
        req2_ff <= req1_ff;
    end

    wire [2:0] mode_s = pin_ff[5:3];
    wire prog_n_s = pin_ff[2];
    wire init_s = pin_ff[1];
    wire done_s = pin_ff[0];
    wire restart = !prog_n_s || ctrl_s_ff[CTRL_PROG_BIT];
    wire wait_all = ctrl_s_ff[CTRL_WAIT_BIT];
    wire [1:0] done_step = ctrl_s_ff[CTRL_DONE_LSB +: 2];
    wire [1:0] gts_step = ctrl_s_ff[CTRL_GTS_LSB +: 2];
    wire [1:0] gwe_step = ctrl_s_ff[CTRL_GWE_LSB +: 2];
    wire serial = fcs_is_serial(mode_ff);
    wire own_take = cfg_strobe && (mode_ff != MODE_BSCAN);
    wire any_take = tap_strobe || own_take;
    wire one_bit = tap_strobe || serial;
    wire [7:0] word = tap_strobe ? {7'h0, tap_bit} :
        (serial ? {7'h0, cfg_data[0]} : cfg_data);
    wire [CNT_W-1:0] incr = one_bit ? CNT_W'(1) : CNT_W'(8);
    wire loaded = cnt_ff >= CNT_W'(LOAD_BITS);
    wire shared_ok = !wait_all || done_s;
    wire done_go = step_ff >= done_step;
    wire gts_go = (step_ff >= gts_step) && shared_ok;
    wire gwe_go = (step_ff >= gwe_step) && shared_ok;
    wire hold_step = wait_all && !done_oe_ff && !done_s;

    always_comb
    begin
        nxt_state = state_ff;
        nxt_clr = clr_ff;
        nxt_cnt = cnt_ff;
        nxt_mode = mode_ff;
        nxt_step = step_ff;
        nxt_check = check_ff;
        nxt_done_oe = done_oe_ff;
        nxt_gts = gts_ff;
        nxt_gwe = gwe_ff;
        case (state_ff)
            ST_CLEAR:
            begin
                nxt_clr = clr_ff + CLR_W'(1);
                if (clr_ff == CLR_W'(CLEAR_CYCLES - 1))
                    nxt_state = ST_WAIT_INIT;
            end
            ST_WAIT_INIT:
            begin
                if (init_s)
                begin
                    nxt_state = ST_LOAD;
                    nxt_mode = mode_s;
                end
            end
            ST_LOAD:
            begin
                if (loaded)
                    nxt_state = ST_GSR;
                else if (any_take)
                begin
                    nxt_cnt = cnt_ff + incr;
                    nxt_check = {check_ff[6:0], check_ff[7]} ^ word;
                end
            end
            ST_GSR:
            begin
                nxt_state = ST_STARTUP;
                nxt_step = 2'h0;
            end
            ST_STARTUP:
            begin
                if (done_go)
                    nxt_done_oe = 1'b0;
                if (gts_go)
                    nxt_gts = 1'b0;
                if (gwe_go)
                    nxt_gwe = 1'b1;
                if (step_ff != STARTUP_LAST && !hold_step)
                    nxt_step = step_ff + 2'h1;
                if (!done_oe_ff && !gts_ff && gwe_ff)
                    nxt_state = ST_RUN;
            end
            ST_RUN:
                nxt_state = ST_RUN;
            default:
                nxt_state = ST_CLEAR;
        endcase
        if (restart)
        begin
            nxt_state = ST_CLEAR;
            nxt_clr = '0;
        end
        if (nxt_state == ST_CLEAR)
        begin
            nxt_cnt = '0;
            nxt_check = 8'h0;
            nxt_done_oe = 1'b1;
            nxt_gts = 1'b1;
            nxt_gwe = 1'b0;
        end
    end

    always_ff @(posedge cfg_clock)
    begin
        if (!lrst_n_ff)
        begin
            state_ff <= ST_CLEAR;
            clr_ff <= '0;
            cnt_ff <= '0;
            mode_ff <= MODE_MSERIAL;
            step_ff <= 2'h0;
            check_ff <= 8'h0;
            init_oe_ff <= 1'b1;
            done_oe_ff <= 1'b1;
            gsr_ff <= 1'b0;
            gts_ff <= 1'b1;
            gwe_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            clr_ff <= nxt_clr;
            cnt_ff <= nxt_cnt;
            mode_ff <= nxt_mode;
            step_ff <= nxt_step;
            check_ff <= nxt_check;
            init_oe_ff <= nxt_state == ST_CLEAR;
            done_oe_ff <= nxt_done_oe;
            gsr_ff <= nxt_state == ST_GSR;
            gts_ff <= nxt_gts;
            gwe_ff <= nxt_gwe;
        end
    end

    // daisy chain output and status capture
    always_ff @(posedge cfg_clock)
    begin
        if (!lrst_n_ff)
        begin
            full_ff <= 1'b0;
            dout_ff <= 1'b1;
            dout_oe_ff <= 1'b0;
            req3_ff <= 1'b0;
            ack_ff <= 1'b0;
            snap_ff <= '0;
            snap_cnt_ff <= '0;
            snap_check_ff <= 8'h0;
        end
        else
        begin
            full_ff <= (nxt_state != ST_CLEAR) && (full_ff || loaded);
            dout_oe_ff <= serial && (state_ff != ST_CLEAR);
            dout_ff <= (serial && full_ff && cfg_strobe) ? cfg_data[0] : 1'b1;
            req3_ff <= req2_ff;
            if (req3_ff != req2_ff)
            begin
                ack_ff <= req2_ff;
                snap_ff <= {full_ff, pullup_enable_ff, gwe_ff, gts_ff,
                    !done_oe_ff, init_s, mode_ff, state_ff};
                snap_cnt_ff <= cnt_ff;
                snap_check_ff <= check_ff;
            end
        end
    end

    assign awready = awready_ff;
    assign wready = wready_ff;
    assign bvalid = bvalid_ff;
    assign bresp = bresp_ff;
    assign arready = arready_ff;
    assign rvalid = rvalid_ff;
    assign rdata = rdata_ff;
    assign rresp = rresp_ff;
    assign pullup_enable = pullup_enable_ff;
    assign cfg_clock_out = cfg_clock_ff;
    assign cfg_clock_oe = cfg_clock_oe_ff;
    assign dout = dout_ff;
    assign dout_oe = dout_oe_ff;
    assign init_out = 1'b0 & init_oe_ff;
    assign init_oe = init_oe_ff;
    assign done_out = 1'b0 & done_oe_ff;
    assign done_oe = done_oe_ff;
    assign global_set_reset = gsr_ff;
    assign global_output_tristate = gts_ff;
    assign global_write_enable = gwe_ff;

    AST_BYTE_WIDE: assert property (@(posedge cfg_clock) disable iff (!lrst_n_ff)
        (state_ff == ST_LOAD && mode_ff == MODE_SBYTE && cfg_strobe &&
            !tap_strobe && !loaded && !restart) |=> cnt_ff == $past(cnt_ff) + CNT_W'(8))
        else $error("byte-wide load did not count eight bits");
    AST_SLAVE_CLOCK: assert property (@(posedge aclk) disable iff (!aresetn)
        (mode_a_ff == MODE_SSERIAL) |=> !cfg_clock_oe)
        else $error("clock driven in slave mode");
    AST_NO_DAISY: assert property (@(posedge cfg_clock) disable iff (!lrst_n_ff)
        (state_ff == ST_LOAD && !serial) |=> !dout_oe)
        else $error("daisy output enabled outside serial mode");
    AST_INIT_WAIT: assert property (@(posedge cfg_clock) disable iff (!lrst_n_ff)
        (state_ff == ST_WAIT_INIT && !init_s && !restart)
            |=> state_ff != ST_LOAD && !init_oe)
        else $error("load entered while init held low");
    AST_RESTART: assert property (@(posedge cfg_clock) disable iff (!lrst_n_ff)
        !prog_n_s |=> state_ff == ST_CLEAR && init_oe && done_oe && gts_ff)
        else $error("program request did not restart");
    AST_GSR_PULSE: assert property (@(posedge cfg_clock) disable iff (!lrst_n_ff)
        $rose(gsr_ff) |-> $past(state_ff) == ST_LOAD ##1 !gsr_ff)
        else $error("set/reset pulse misplaced");
    AST_GTS_STEP: assert property (@(posedge cfg_clock) disable iff (!lrst_n_ff)
        ($fell(done_oe_ff) && ctrl_s_ff == CTRL_RESET && !restart)
            |=> $fell(gts_ff))
        else $error("3-state not released one cycle after done");
    AST_GWE_STEP: assert property (@(posedge cfg_clock) disable iff (!lrst_n_ff)
        ($fell(gts_ff) && ctrl_s_ff == CTRL_RESET && !restart) |=> $rose(gwe_ff))
        else $error("write enable not released one cycle after 3-state");
    AST_SHARED_DONE: assert property (@(posedge cfg_clock) disable iff (!lrst_n_ff)
        (wait_all && !done_s && gts_ff) |=> gts_ff)
        else $error("3-state released before shared done");
    AST_HOLD_EARLY: assert property (@(posedge cfg_clock) disable iff (!lrst_n_ff)
        (state_ff inside {ST_CLEAR, ST_WAIT_INIT, ST_LOAD, ST_GSR})
            |-> done_oe && gts_ff && !gwe_ff)
        else $error("global controls released before start-up");

endmodule : fcs_config_sequencer
`default_nettype wire

//--- test/fcs_cfg_source.sv
`timescale 1ns/1ns
`default_nettype none
module fcs_cfg_source
(
    // design side
    input wire logic cfg_clock_out,
    input wire logic cfg_clock_oe,
    input wire logic init_oe,
    input wire logic done_oe,
    // bench control
    input wire logic hold_init,
    input wire logic hold_done,
    input wire logic go,
    input wire logic use_tap,
    input wire logic [4:0] nstr,
    // link
    output logic cfg_clock,
    output logic init_in,
    output logic done_in,
    output logic [7:0] cfg_data,
    output logic cfg_strobe,
    output logic tap_bit,
    output logic tap_strobe
);
    logic sclk = 1'b0;
    int wait_n = 0;
    int sent = 0;
    always
    begin
        #62 sclk = 1'b1;
        #63 sclk = 1'b0;
    end
    // master loops its own clock back
    assign cfg_clock = cfg_clock_oe ? cfg_clock_out : sclk;
    // open drain, pull-up otherwise
    assign init_in = !(init_oe || hold_init);
    assign done_in = !(done_oe || hold_done);
    initial
    begin
        {cfg_data, cfg_strobe, tap_bit, tap_strobe} = '0;
    end
    // nstr units after init seen high
    always @(posedge cfg_clock)
    begin
        wait_n <= (go && init_in) ? wait_n + 1 : 0;
        cfg_strobe <= 1'b0;
        tap_strobe <= 1'b0;
        cfg_data <= ~cfg_data;
        tap_bit <= ~tap_bit;
        if (!go)
            sent <= 0;
        else if (wait_n >= 6 && sent < nstr)
        begin
            sent <= sent + 1;
            cfg_data <= 8'($urandom);
            tap_bit <= 1'($urandom);
            cfg_strobe <= !use_tap;
            tap_strobe <= use_tap;
        end
    end
endmodule : fcs_cfg_source
`default_nettype wire

//--- test/testbench.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
    num_errors++; $display("mismatch %s exp %0h got %0h", n, e, g); end end
module testbench;
    import fcs_pkg::*;
    localparam int LB = 16;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, mode_sel_hi, mode_sel_mid;
    logic mode_sel_lo, pullup_control, program_request_n, pullup_enable;
    logic cfg_clock, cfg_clock_out, cfg_clock_oe, cfg_strobe, tap_bit;
    logic tap_strobe, dout, dout_oe, init_in, init_out, init_oe, done_in;
    logic done_out, done_oe, global_set_reset, global_output_tristate;
    logic global_write_enable, hold_init, hold_done, go, use_tap;
    logic [3:0] awaddr, araddr, wstrb;
    logic [31:0] wdata, rdata, d;
    logic [1:0] bresp, rresp;
    logic [7:0] cfg_data;
    logic [4:0] nstr;
    logic [2:0] modes [5] = '{3'h7, 3'h3, 3'h6, 3'h5, 3'h0};
    logic [7:0] ctrls [5] = '{8'hd0, 8'h90, 8'he0, 8'h90, 8'h92};
    int num_errors = 0;
    int num_checks = 0;
    fcs_config_sequencer #(.CLEAR_CYCLES(4), .LOAD_BITS(LB)) dut_u (.*);
    fcs_cfg_source src_u (.*);
    always #25 aclk = ~aclk;
    task automatic complete_run;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run
    task automatic axw(input logic [3:0] a, input logic [31:0] v,
        input logic [1:0] er);
        int n;
        logic ar, wr, b;
        n = 0;
        b = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        {awvalid, wvalid, bready} <= 3'h7;
        do
        begin
            @(negedge aclk);
            {ar, wr, b} = {awready, wready, bvalid};
            @(posedge aclk);
            n++;
            if (ar)
                awvalid <= 1'b0;
            if (wr)
                wvalid <= 1'b0;
        end
        while (b !== 1'b1 && n < 50);
        bready <= 1'b0;
        `CHK("bvalid", 1'b1, b)
        `CHK("bresp", er, bresp)
    endtask : axw
    task automatic axr(input logic [3:0] a, input logic [1:0] er);
        int n;
        logic ar, rv;
        logic [1:0] rs;
        n = 0;
        rv = 1'b0;
        @(posedge aclk);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        do
        begin
            @(negedge aclk);
            {ar, rv, rs} = {arready, rvalid, rresp};
            d = rdata;
            @(posedge aclk);
            n++;
            if (ar)
                arvalid <= 1'b0;
        end
        while (rv !== 1'b1 && n < 50);
        rready <= 1'b0;
        `CHK("rvalid", 1'b1, rv)
        `CHK("rresp", er, rs)
    endtask : axr
    task automatic run_cfg(input logic [2:0] m, input logic [7:0] c,
        input int kind, input logic wd);
        int n;
        int g1;
        int g2;
        g1 = int'(c[5:4]) - int'(c[3:2]);
        g2 = int'(c[7:6]) - int'(c[5:4]);
        @(posedge aclk);
        {mode_sel_hi, mode_sel_mid, mode_sel_lo} <= m;
        use_tap <= (m == 3'h5);
        nstr <= (m == 3'h3 || m == 3'h6) ? 5'h2 : 5'h10;
        {hold_init, go, hold_done} <= {2'h2, wd};
        if (kind != 0)
            axw(REG_CTRL, {24'h0, c | {7'h0, kind == 2}}, RESP_OKAY);
        if (kind == 1)
            program_request_n <= 1'b0;
        repeat (kind ? 24 : 0) @(posedge aclk);
        `CHK("init_oe", 1'b1, init_oe)
        `CHK("done_oe", 1'b1, done_oe)
        `CHK("gts", 1'b1, global_output_tristate)
        `CHK("gwe", 1'b0, global_write_enable)
        program_request_n <= 1'b1;
        if (kind == 2)
            axw(REG_CTRL, {24'h0, c}, RESP_OKAY);
        n = 0;
        while (init_oe !== 1'b0 && n < 400)
        begin
            @(posedge aclk);
            n++;
        end
        `CHK("init_rel", 1'b0, init_oe)
        repeat (30) @(posedge aclk);
        axr(REG_STATUS, RESP_OKAY);
        `CHK("held", 3'h1, d[2:0])
        {hold_init, go} <= 2'h1;
        `CHK("cfg_clock_oe", m == 3'h0 || m == 3'h3, cfg_clock_oe)
        n = 0;
        while (global_set_reset !== 1'b1 && n < 200)
        begin
            @(negedge cfg_clock);
            n++;
        end
        `CHK("gsr", 1'b1, global_set_reset)
        `CHK("done_gsr", 1'b1, done_oe)
        `CHK("dout_oe", m == 3'h0 || m == 3'h7, dout_oe)
        @(negedge cfg_clock);
        `CHK("gsr_len", 1'b0, global_set_reset)
        n = 0;
        while (done_oe !== 1'b0 && n < 50)
        begin
            @(negedge cfg_clock);
            n++;
        end
        n = 0;
        if (wd)
        begin
            repeat (8) @(negedge cfg_clock);
            `CHK("gts_wait", 1'b1, global_output_tristate)
            @(posedge aclk);
            hold_done <= 1'b0;
        end
        while (global_output_tristate === 1'b1 && n < 40)
        begin
            @(negedge cfg_clock);
            n++;
        end
        `CHK("gts_gap", wd ? 1 : g1, wd ? int'(n < 6) : n)
        n = 0;
        while (global_write_enable !== 1'b1 && n < 40)
        begin
            @(negedge cfg_clock);
            n++;
        end
        `CHK("gwe_gap", g2, n)
        `CHK("gwe_on", 1'b1, global_write_enable)
        @(posedge aclk);
        go <= 1'b0;
        repeat (40) @(posedge aclk);
        axr(REG_COUNT, RESP_OKAY);
        `CHK("count", LB, d)
        axr(REG_STATUS, RESP_OKAY);
        `CHK("status", {4'hb, m, 3'h5}, d[9:0])
    endtask : run_cfg
    initial
    begin
        void'($urandom(32'hf11b));
        {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {mode_sel_hi, mode_sel_mid, mode_sel_lo, pullup_control} = '0;
        {hold_done, go, use_tap, awaddr, araddr, wdata} = '0;
        {program_request_n, hold_init, wstrb, nstr} = {2'h3, 4'hf, 5'h10};
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        run_cfg(3'h0, CTRL_RESET, 0, 1'b0);
        axr(REG_CTRL, RESP_OKAY);
        `CHK("ctrl_rst", 32'h90, d)
        axr(4'h2, RESP_SLVERR);
        axw(4'h6, 32'h0, RESP_SLVERR);
        for (int i = 0; i < 5; i++)
        begin
            pullup_control <= 1'($urandom);
            run_cfg(modes[i], ctrls[i], i % 2 + 1, i == 4);
            `CHK("pullup", pullup_control, pullup_enable)
        end
        complete_run();
    end
    initial
    begin
        #500000;
        num_errors++;
        complete_run();
    end
endmodule : testbench
`default_nettype wire
